// File: logic/tlic_consts.svh
`ifndef TLIC_CONSTS_SVH
`define TLIC_CONSTS_SVH

// ==========================================================
// Register addresses and reset values
`define TLIC_ADDR_ENABLE_MAIN   8'ha8
`define TLIC_ADDR_SECONDARY     8'ha9
`define TLIC_ADDR_PRIORITY_MAIN 8'hb8
`define TLIC_RST_ENABLE_MAIN    8'h00
`define TLIC_RST_SECONDARY      8'ha0
`define TLIC_RST_PRIORITY_MAIN  8'h00

// ==========================================================
// Field positions
`define TLIC_BIT_GLOBAL_GATE    3'd7
`define TLIC_SEC_LEVEL_LSB      4
`define TLIC_SEC_ENABLE_LSB     0
`define TLIC_SEC_RSVD_BIT       3
`define TLIC_SEC_RSVD_HIGH_BIT  7
`define TLIC_NUM_SRC            11
`define TLIC_BIT_PIN0           3'd0
`define TLIC_BIT_TIMER0         3'd1
`define TLIC_BIT_PIN1           3'd2
`define TLIC_BIT_TIMER1         3'd3
`define TLIC_BIT_UART           3'd4
`define TLIC_BIT_TIMER2         3'd5
`define TLIC_BIT_CONV           3'd6
`define TLIC_BIT_PRIO_RSVD      3'd7

// ==========================================================
// Source indices in polling order, highest first
`define TLIC_SRC_SUPPLY   4'd0
`define TLIC_SRC_WATCHDOG 4'd1
`define TLIC_SRC_PIN0     4'd2
`define TLIC_SRC_CONV     4'd3
`define TLIC_SRC_TIMER0   4'd4
`define TLIC_SRC_PIN1     4'd5
`define TLIC_SRC_TIMER1   4'd6
`define TLIC_SRC_SERIAL   4'd7
`define TLIC_SRC_UART     4'd8
`define TLIC_SRC_TIMER2   4'd9
`define TLIC_SRC_INTERVAL 4'd10

// ==========================================================
// Vector addresses
`define TLIC_VEC_PIN0     16'h0003
`define TLIC_VEC_TIMER0   16'h000b
`define TLIC_VEC_PIN1     16'h0013
`define TLIC_VEC_TIMER1   16'h001b
`define TLIC_VEC_UART     16'h0023
`define TLIC_VEC_TIMER2   16'h002b
`define TLIC_VEC_CONV     16'h0033
`define TLIC_VEC_SERIAL   16'h003b
`define TLIC_VEC_SUPPLY   16'h0043
`define TLIC_VEC_INTERVAL 16'h0053
`define TLIC_VEC_WATCHDOG 16'h005b

`endif

// File: logic/tlic_pkg.sv
package tlic_pkg;

    typedef enum logic [1:0] {
        TLIC_IDLE  = 2'b00,
        TLIC_PUSH  = 2'b01,
        TLIC_LOAD  = 2'b10
    } tlic_seq_type;

    typedef struct packed {
        logic [7:0]   enable_main;
        logic [7:0]   priority_main;
        logic [7:0]   secondary;
        logic         low_active;
        logic         high_active;
        tlic_seq_type seq;
        logic         take_high;
        logic [15:0]  vector;
        logic         push_req;
        logic         load_req;
        logic [7:0]   rd_data;
    } tlic_state_type;

endpackage : tlic_pkg

// File: logic/tlic_arbiter.sv
`timescale 1ns/100ps
`include "tlic_consts.svh"

module tlic_arbiter (
    // Requests, already enabled, and their levels
    input  wire logic [10:0] req,
    input  wire logic [10:0] level,
    // In-service state
    input  wire logic        low_active,
    input  wire logic        high_active,
    // Chosen source
    output logic             take,
    output logic             take_high,
    output logic [3:0]       take_src
);

    // ==========================================================
    // Fixed polling within each level
    logic [10:0] hi_req;
    logic [10:0] lo_req;
    logic        hi_any;
    logic        lo_any;
    logic [3:0]  hi_src;
    logic [3:0]  lo_src;

    function automatic logic [3:0] tlic_first(input logic [10:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 10; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : tlic_first

    always_comb begin
        hi_req    = req & level;
        lo_req    = req & ~level;
        hi_any    = |hi_req;
        lo_any    = |lo_req;
        hi_src    = tlic_first(hi_req);
        lo_src    = tlic_first(lo_req);
        take      = 1'b0;
        take_high = 1'b0;
        take_src  = 4'h0;
        if (hi_any && !high_active) begin
            take      = 1'b1;
            take_high = 1'b1;
            take_src  = hi_src;
        end else if (lo_any && !high_active && !low_active) begin
            take     = 1'b1;
            take_src = lo_src;
        end
    end

endmodule : tlic_arbiter

// File: logic/tlic_ctrl.sv
`timescale 1ns/100ps
`include "tlic_consts.svh"
// Functional notes
// - Enable bit 7 gates every source; zero means nothing is serviced.
// - Enable bits 6..0: converter, timer2, uart, timer1, pin1, timer0, pin0.
// - Main enable at A8H, resets 00H, bit addressable.
// - Priority bits 6..0 same order; one is high level; bit 7 reserved.
// - Priority at B8H, resets 00H, bit addressable.
// - Secondary register at A9H, resets A0H, byte access only.
// - Secondary bits 6..4 levels, 2..0 enables: interval, supply, serial.
// - High-level request pre-empts a running low-level routine.
// - Simultaneous different levels: high level vectored first.
// - Same-level request waits until the running routine ends.
// - Same-level ties follow fixed polling order, supply monitor first.
// - Accepting pushes program counter, then loads vector.
// - Each source has a fixed vector address.

module tlic_ctrl (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    // Special-function register port
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_bit_wr,
    input  wire logic [2:0]  sfr_bit_sel,
    input  wire logic        sfr_bit_val,
    output logic      [7:0]  sfr_rdata,
    output logic             sfr_hit,
    // Source requests
    input  wire logic        supply_monitor_request,
    input  wire logic        watchdog_request,
    input  wire logic        pin0_request,
    input  wire logic        converter_request,
    input  wire logic        timer0_overflow_flag,
    input  wire logic        pin1_request,
    input  wire logic        timer1_overflow_flag,
    input  wire logic        serial_port_request,
    input  wire logic        uart_rx_done_flag,
    input  wire logic        uart_tx_done_flag,
    input  wire logic        timer2_overflow_flag,
    input  wire logic        timer2_capture_flag,
    input  wire logic        interval_counter_request,
    // Core handshake
    input  wire logic        core_ready,
    input  wire logic        core_return,
    output logic             pc_push,
    output logic             pc_load,
    output logic      [15:0] pc_vector,
    output logic             low_in_service,
    output logic             high_in_service
);

    // ==========================================================
    // State
    tlic_pkg::tlic_state_type s_q;
    tlic_pkg::tlic_state_type s_d;

    logic [10:0] req;
    logic [10:0] level;
    logic        take;
    logic        take_high;
    logic [3:0]  take_src;
    logic        gate;
    logic [7:0]  sec_w;

    function automatic logic [15:0] tlic_vec(input logic [3:0] src);
        case (src)
            `TLIC_SRC_SUPPLY:   tlic_vec = `TLIC_VEC_SUPPLY;
            `TLIC_SRC_WATCHDOG: tlic_vec = `TLIC_VEC_WATCHDOG;
            `TLIC_SRC_PIN0:     tlic_vec = `TLIC_VEC_PIN0;
            `TLIC_SRC_CONV:     tlic_vec = `TLIC_VEC_CONV;
            `TLIC_SRC_TIMER0:   tlic_vec = `TLIC_VEC_TIMER0;
            `TLIC_SRC_PIN1:     tlic_vec = `TLIC_VEC_PIN1;
            `TLIC_SRC_TIMER1:   tlic_vec = `TLIC_VEC_TIMER1;
            `TLIC_SRC_SERIAL:   tlic_vec = `TLIC_VEC_SERIAL;
            `TLIC_SRC_UART:     tlic_vec = `TLIC_VEC_UART;
            `TLIC_SRC_TIMER2:   tlic_vec = `TLIC_VEC_TIMER2;
            `TLIC_SRC_INTERVAL: tlic_vec = `TLIC_VEC_INTERVAL;
            default:            tlic_vec = `TLIC_VEC_PIN0;
        endcase
    endfunction : tlic_vec

    // ==========================================================
    // Request gathering
    always_comb begin
        gate = s_q.enable_main[`TLIC_BIT_GLOBAL_GATE];
        req = '0;
        req[`TLIC_SRC_SUPPLY]   = supply_monitor_request & s_q.secondary[`TLIC_SEC_ENABLE_LSB + 1];
        // Watchdog has no enable bit and shares the pin0 priority bit
        req[`TLIC_SRC_WATCHDOG] = watchdog_request;
        req[`TLIC_SRC_PIN0]     = pin0_request & s_q.enable_main[`TLIC_BIT_PIN0];
        req[`TLIC_SRC_CONV]     = converter_request & s_q.enable_main[`TLIC_BIT_CONV];
        req[`TLIC_SRC_TIMER0]   = timer0_overflow_flag & s_q.enable_main[`TLIC_BIT_TIMER0];
        req[`TLIC_SRC_PIN1]     = pin1_request & s_q.enable_main[`TLIC_BIT_PIN1];
        req[`TLIC_SRC_TIMER1]   = timer1_overflow_flag & s_q.enable_main[`TLIC_BIT_TIMER1];
        req[`TLIC_SRC_SERIAL]   = serial_port_request & s_q.secondary[`TLIC_SEC_ENABLE_LSB];
        req[`TLIC_SRC_UART]     = (uart_rx_done_flag | uart_tx_done_flag) & s_q.enable_main[`TLIC_BIT_UART];
        req[`TLIC_SRC_TIMER2]   = (timer2_overflow_flag | timer2_capture_flag)
                                  & s_q.enable_main[`TLIC_BIT_TIMER2];
        req[`TLIC_SRC_INTERVAL] = interval_counter_request & s_q.secondary[`TLIC_SEC_ENABLE_LSB + 2];
        req = gate ? req : '0;
        level = '0;
        level[`TLIC_SRC_SUPPLY]   = s_q.secondary[`TLIC_SEC_LEVEL_LSB + 1];
        level[`TLIC_SRC_WATCHDOG] = s_q.priority_main[`TLIC_BIT_PIN0];
        level[`TLIC_SRC_PIN0]     = s_q.priority_main[`TLIC_BIT_PIN0];
        level[`TLIC_SRC_CONV]     = s_q.priority_main[`TLIC_BIT_CONV];
        level[`TLIC_SRC_TIMER0]   = s_q.priority_main[`TLIC_BIT_TIMER0];
        level[`TLIC_SRC_PIN1]     = s_q.priority_main[`TLIC_BIT_PIN1];
        level[`TLIC_SRC_TIMER1]   = s_q.priority_main[`TLIC_BIT_TIMER1];
        level[`TLIC_SRC_SERIAL]   = s_q.secondary[`TLIC_SEC_LEVEL_LSB];
        level[`TLIC_SRC_UART]     = s_q.priority_main[`TLIC_BIT_UART];
        level[`TLIC_SRC_TIMER2]   = s_q.priority_main[`TLIC_BIT_TIMER2];
        level[`TLIC_SRC_INTERVAL] = s_q.secondary[`TLIC_SEC_LEVEL_LSB + 2];
    end

    tlic_arbiter u_arbiter (
        .req         (req),
        .level       (level),
        .low_active  (s_q.low_active),
        .high_active (s_q.high_active),
        .take        (take),
        .take_high   (take_high),
        .take_src    (take_src)
    );

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.push_req = 1'b0;
        s_d.load_req = 1'b0;
        sec_w = sfr_wdata;
        sec_w[`TLIC_SEC_RSVD_BIT] = 1'b0;
        sec_w[`TLIC_SEC_RSVD_HIGH_BIT] = s_q.secondary[`TLIC_SEC_RSVD_HIGH_BIT];
        // Register writes
        if (sfr_wr) begin
            case (sfr_addr)
                `TLIC_ADDR_ENABLE_MAIN:   s_d.enable_main = sfr_wdata;
                `TLIC_ADDR_PRIORITY_MAIN: s_d.priority_main = {1'b0, sfr_wdata[6:0]};
                `TLIC_ADDR_SECONDARY:     s_d.secondary = sec_w;
                default: ;
            endcase
        end else if (sfr_bit_wr) begin
            case (sfr_addr)
                `TLIC_ADDR_ENABLE_MAIN:   s_d.enable_main[sfr_bit_sel] = sfr_bit_val;
                `TLIC_ADDR_PRIORITY_MAIN: begin
                    s_d.priority_main[sfr_bit_sel] = sfr_bit_val;
                    s_d.priority_main[`TLIC_BIT_PRIO_RSVD] = 1'b0;
                end
                default: ;
            endcase
        end
        // Read data
        case (sfr_addr)
            `TLIC_ADDR_ENABLE_MAIN:   s_d.rd_data = s_q.enable_main;
            `TLIC_ADDR_PRIORITY_MAIN: s_d.rd_data = s_q.priority_main;
            `TLIC_ADDR_SECONDARY:     s_d.rd_data = s_q.secondary;
            default:                  s_d.rd_data = 8'h00;
        endcase
        // Release on return: high level first, as it is the innermost
        if (core_return) begin
            if (s_q.high_active) begin
                s_d.high_active = 1'b0;
            end else begin
                s_d.low_active = 1'b0;
            end
        end
        // Vectoring sequence
        case (s_q.seq)
            tlic_pkg::TLIC_IDLE: begin
                if (take && core_ready && !core_return) begin
                    s_d.take_high = take_high;
                    s_d.vector    = tlic_vec(take_src);
                    s_d.push_req  = 1'b1;
                    if (take_high) begin
                        s_d.high_active = 1'b1;
                    end else begin
                        s_d.low_active = 1'b1;
                    end
                    s_d.seq = tlic_pkg::TLIC_PUSH;
                end
            end
            tlic_pkg::TLIC_PUSH: begin
                s_d.load_req = 1'b1;
                s_d.seq      = tlic_pkg::TLIC_LOAD;
            end
            tlic_pkg::TLIC_LOAD: begin
                s_d.seq = tlic_pkg::TLIC_IDLE;
            end
            default: begin
                s_d.seq = tlic_pkg::TLIC_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_q.enable_main   <= `TLIC_RST_ENABLE_MAIN;
            s_q.priority_main <= `TLIC_RST_PRIORITY_MAIN;
            s_q.secondary     <= `TLIC_RST_SECONDARY;
            s_q.low_active    <= 1'b0;
            s_q.high_active   <= 1'b0;
            s_q.seq           <= tlic_pkg::TLIC_IDLE;
            s_q.take_high     <= 1'b0;
            s_q.vector        <= 16'h0000;
            s_q.push_req      <= 1'b0;
            s_q.load_req      <= 1'b0;
            s_q.rd_data       <= 8'h00;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        sfr_rdata       = s_q.rd_data;
        sfr_hit         = (sfr_addr == `TLIC_ADDR_ENABLE_MAIN) || (sfr_addr == `TLIC_ADDR_PRIORITY_MAIN)
                          || (sfr_addr == `TLIC_ADDR_SECONDARY);
        pc_push         = s_q.push_req;
        pc_load         = s_q.load_req;
        pc_vector       = s_q.vector;
        low_in_service  = s_q.low_active;
        high_in_service = s_q.high_active;
    end

endmodule : tlic_ctrl

// File: verification/tlic_core_model.sv
`timescale 1ns/100ps
// ==========================================================
// Core side of the vector handshake
module tlic_core_model (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // Controller side
    input  wire logic pc_load,
    output logic      core_ready,
    output logic      core_return,
    // Bench control
    input  wire logic slow,
    input  wire logic ret_req
);
    logic [1:0] busy_q;
    // Slow mode keeps the core busy for three cycles after each vector load
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            busy_q      <= 2'h0;
            core_return <= 1'b0;
        end else begin
            busy_q      <= (pc_load && slow) ? 2'h3 : ((busy_q != 2'h0) ? busy_q - 2'h1 : 2'h0);
            core_return <= ret_req;
        end
    end
    assign core_ready = (busy_q == 2'h0);
endmodule : tlic_core_model

// File: verification/tlic_ctrl_sva.sv
`timescale 1ns/100ps
// ==========================================================
// Checker on the controller ports
module tlic_ctrl_sva (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        clk_en,
    // Register port
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_wr,
    input wire logic        sfr_bit_wr,
    input wire logic [2:0]  sfr_bit_sel,
    input wire logic        sfr_bit_val,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        sfr_hit,
    // Core handshake
    input wire logic        core_ready,
    input wire logic        core_return,
    input wire logic        pc_push,
    input wire logic        pc_load,
    input wire logic [15:0] pc_vector,
    input wire logic        low_in_service,
    input wire logic        high_in_service
);
    logic gate_q;
    // Shadow of the global gate
    always_ff @(posedge clk_sys) begin
        if (!rst_b)
            gate_q <= 1'b0;
        else if (clk_en && sfr_wr && sfr_addr == 8'ha8)
            gate_q <= sfr_wdata[7];
        else if (clk_en && sfr_bit_wr && sfr_addr == 8'ha8 && sfr_bit_sel == 3'h7)
            gate_q <= sfr_bit_val;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    AST_PUSH_THEN_LOAD: assert property (pc_push |=> pc_load && !pc_push)
        else $error("vector load did not follow push");
    AST_LOAD_AFTER_PUSH: assert property (pc_load |-> $past(pc_push))
        else $error("vector load without push");
    AST_GATE: assert property (pc_push |-> $past(gate_q))
        else $error("acceptance with global gate off");
    AST_READY: assert property (pc_push |-> $past(core_ready) && !$past(core_return))
        else $error("acceptance while core not ready");
    AST_VECTOR: assert property (pc_push |-> pc_vector inside {16'h0003, 16'h000b, 16'h0013, 16'h001b,
        16'h0023, 16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h0053, 16'h005b}) else $error("illegal vector");
    AST_NO_HIGH_NEST: assert property (pc_push |-> !$past(high_in_service))
        else $error("high level routine interrupted");
    AST_PREEMPT: assert property (pc_push && $past(low_in_service) |-> high_in_service)
        else $error("low level routine interrupted by low request");
    AST_RETURN_HIGH: assert property (core_return && high_in_service |=> !high_in_service)
        else $error("high level not released on return");
    AST_RETURN_LOW: assert property (core_return && !high_in_service |=> !low_in_service)
        else $error("low level not released on return");
    AST_SPACING: assert property (pc_push |=> !pc_push ##1 !pc_push)
        else $error("acceptances too close");
    AST_HIT: assert property (sfr_hit == (sfr_addr inside {8'ha8, 8'ha9, 8'hb8}))
        else $error("address decode wrong");
    AST_PRIO_RSVD: assert property ($past(sfr_addr) == 8'hb8 |-> !sfr_rdata[7])
        else $error("priority bit 7 reads one");
    AST_SEC_BITS: assert property ($past(sfr_addr) == 8'ha9 |-> !sfr_rdata[3] && sfr_rdata[7])
        else $error("secondary fixed bits wrong");
    cover property (pc_push && low_in_service && high_in_service);
    cover property (core_return && low_in_service);
    cover property (pc_load && pc_vector == 16'h005b);
endmodule : tlic_ctrl_sva

bind tlic_ctrl tlic_ctrl_sva tlic_ctrl_sva_i (.clk_sys, .rst_b, .clk_en, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .sfr_rdata, .sfr_hit, .core_ready, .core_return, .pc_push,
    .pc_load, .pc_vector, .low_in_service, .high_in_service);

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
    // ==========================================================
    // Signals
    logic        clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, sfr_wr = 1'b0, sfr_bit_wr = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [2:0]  sfr_bit_sel = 3'h0;
    logic        sfr_bit_val = 1'b0, slow = 1'b0, ret_req = 1'b0, sfr_hit;
    logic        core_ready, core_return, pc_push, pc_load, low_in_service, high_in_service;
    logic [12:0] rq = 13'h0000;
    logic [15:0] pc_vector;
    int          failures = 0, total_checks = 0, cyc = 0;
    logic [15:0] vec_tab [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
                                  16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
    logic [12:0] msk_tab [11] = '{13'h0001, 13'h0002, 13'h0004, 13'h0008, 13'h0010, 13'h0020,
                                  13'h0040, 13'h0080, 13'h0300, 13'h0c00, 13'h1000};
    // ==========================================================
    // Design and core
    tlic_ctrl tlic_ctrl_i (.clk_sys, .rst_b, .clk_en, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_bit_wr,
        .sfr_bit_sel, .sfr_bit_val, .sfr_rdata, .sfr_hit, .supply_monitor_request(rq[0]),
        .watchdog_request(rq[1]), .pin0_request(rq[2]), .converter_request(rq[3]),
        .timer0_overflow_flag(rq[4]), .pin1_request(rq[5]), .timer1_overflow_flag(rq[6]),
        .serial_port_request(rq[7]), .uart_rx_done_flag(rq[8]), .uart_tx_done_flag(rq[9]),
        .timer2_overflow_flag(rq[10]), .timer2_capture_flag(rq[11]), .interval_counter_request(rq[12]),
        .core_ready, .core_return, .pc_push, .pc_load, .pc_vector, .low_in_service, .high_in_service);
    tlic_core_model tlic_core_model_i (.clk_sys, .rst_b, .pc_load, .core_ready, .core_return, .slow, .ret_req);
    always #2 clk_sys = ~clk_sys;
    // ==========================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_bit_val = d[0];
        sfr_bit_sel = s;
        sfr_wr = !b;
        sfr_bit_wr = b;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
        sfr_bit_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        sfr_addr = a;
        @(negedge clk_sys);
        chk({8'h00, sfr_rdata}, {8'h00, exp});
        chk({15'h0000, sfr_hit}, {15'h0000, a inside {8'ha8, 8'ha9, 8'hb8}});
    endtask : rd
    task automatic take(input logic [15:0] exp);
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (pc_push !== 1'b1 && n < 40);
        chk({15'h0000, pc_push}, 16'h0001);
        chk(pc_vector, exp);
        @(negedge clk_sys);
        chk({15'h0000, pc_load}, 16'h0001);
    endtask : take
    task automatic ret;
        @(negedge clk_sys);
        ret_req = 1'b1;
        @(negedge clk_sys);
        ret_req = 1'b0;
        @(negedge clk_sys);
    endtask : ret
    task automatic quiet(input int n);
        int c;
        c = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (pc_push === 1'b1) c++;
        end
        chk(c[15:0], 16'h0000);
    endtask : quiet
    task automatic print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            print_verdict();
        end
    end
    // ==========================================================
    // Sequence
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        rd(8'ha8, 8'h00);
        rd(8'ha9, 8'ha0);
        rd(8'hb8, 8'h00);
        rd(8'h55, 8'h00);
        clk_en = 1'b0;
        wr(8'ha8, 8'h80, 1'b0, 3'h0);
        clk_en = 1'b1;
        rd(8'ha8, 8'h00);
        wr(8'ha9, 8'h7f, 1'b0, 3'h0);
        rd(8'ha9, 8'hf7);
        wr(8'ha9, 8'h00, 1'b1, 3'h2);
        rd(8'ha9, 8'hf7);
        wr(8'hb8, 8'hff, 1'b0, 3'h0);
        rd(8'hb8, 8'h7f);
        wr(8'hb8, 8'h00, 1'b0, 3'h0);
        wr(8'ha8, 8'h7f, 1'b0, 3'h0);
        rq = 13'h0004;
        quiet(10);
        wr(8'ha8, 8'h01, 1'b1, 3'h7);
        take(16'h0003);
        rq = 13'h0000;
        ret();
        rd(8'ha8, 8'hff);
        wr(8'ha9, 8'h07, 1'b0, 3'h0);
        slow = 1'b1;
        rq = 13'h1fff;
        for (int k = 0; k < 11; k++) begin
            take(vec_tab[k]);
            rq = rq & ~msk_tab[k];
            ret();
        end
        slow = 1'b0;
        rq = 13'h0200;
        take(16'h0023);
        rq = 13'h0000;
        ret();
        rq = 13'h0800;
        take(16'h002b);
        rq = 13'h0000;
        ret();
        wr(8'hb8, 8'h01, 1'b1, 3'h3);
        rq = 13'h0044;
        take(16'h001b);
        rq = 13'h0004;
        ret();
        take(16'h0003);
        rq = 13'h0044;
        take(16'h001b);
        chk({14'h0000, low_in_service, high_in_service}, 16'h0003);
        rq = 13'h0008;
        ret();
        quiet(8);
        ret();
        take(16'h0033);
        rq = 13'h0000;
        ret();
        print_verdict();
    end
endmodule : tb
